// File: logic/sar_adc_pkg.sv
// Purpose: shared constants and types of the converter control and readout logic
// Assumes: core clock of 200 MHz; all times are turned into cycles here
// Notes: a least time rounds up, a longest time rounds down
package sar_adc_pkg;

  localparam int CLK_PERIOD_NS = 5;
  localparam int RESULT_W = 16;

  // longest conversion time and the cycles of one approximation step
  localparam int CONV_MAX_NS = 2500;
  localparam int CONV_MAX_CYC = CONV_MAX_NS / CLK_PERIOD_NS;
  localparam int STEP_CYC = CONV_MAX_CYC / RESULT_W;

  // recovery after the reset pin falls: acquisition time plus a fixed margin
  localparam int ACQ_MAX_NS = 1485;
  localparam int RESET_EXTRA_NS = 2000;
  localparam int RECOVER_CYC =
    (ACQ_MAX_NS + RESET_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // least high time of the start strobe to leave nap
  localparam int NAP_WAKE_NS = 250;
  localparam int NAP_WAKE_CYC = (NAP_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [15:0] TRIAL_START = 16'h8000;
  localparam logic [3:0] TOP_BIT_IDX = 4'hF;
  localparam logic [11:0] WAIT_RST = 12'h000;
  localparam logic [7:0] STEP_RST = 8'h00;

  // rising shift edges after which the chain input reaches the output
  localparam logic [4:0] CHAIN_AT = 5'h10;

  typedef enum logic [4:0] {
    ST_RECOVER  = 5'h01,
    ST_ACQUIRE  = 5'h02,
    ST_CONVERT  = 5'h04,
    ST_NAP      = 5'h08,
    ST_SHUTDOWN = 5'h10
  } ctrl_state_t;

  typedef struct packed {
    logic conv_n;
    logic pd;
    logic dev_reset;
    logic cs_n;
    logic rd_n;
    logic ser_sel;
    logic swap;
    logic fmt_ob;
    logic cmp;
  } pin_bundle_t;

  localparam pin_bundle_t PINS_RST = 9'h1D8;

endpackage

// File: logic/sar_adc_ctrl.sv
// Purpose: conversion sequencing, power states and parallel/serial readout of a
//   16-bit successive-approximation converter
// Assumes: pins are asynchronous to clk; shift_clk comes from the host and may stop
// Notes: output enables are active low; the testbench resolves only the serial data wire
// Notes on behaviour
// - start strobe falling edge begins conversion; busy stays high throughout it
// - start edges during a conversion are ignored until it completes
// - conversion lasts at most 2500ns; acquisition at most 1485ns
// - strobe held low after a conversion puts the device in nap
// - power-down high means shutdown and every start request is ignored
// - power-down during conversion: finish it first, keep result readable afterwards
// - chip select or read high tristates all data outputs
// - parallel select with chip select and read low drives the 16-bit word
// - byte swap low: upper byte high lines; high: bytes exchanged
// - serial select with chip select and read low shifts result out
// - serial bit changes on rising shift edge; host samples on falling
// - top bit shows first, valid until rising edge after first falling edge
// - in serial mode unused outputs stay high impedance
// - chain input follows own result; captured on falling edges, out after 16
// - format high gives offset binary; low inverts the top bit
// - reset pin aborts conversion, tristates, ignores starts; acquisition plus 2us recovery
module sar_adc_ctrl (
  input wire logic clk, // core clock, 200 MHz
  input wire logic rst, // asynchronous reset, active high
  input wire logic shift_clk, // serial shift clock from the host
  input wire logic conversion_start_n, // start strobe, falling edge starts
  input wire logic power_down_request, // high requests shutdown
  input wire logic device_reset, // reset pin, active high
  input wire logic chip_select_n, // chip select, active low
  input wire logic read_n, // read, active low
  input wire logic interface_select, // low parallel, high serial
  input wire logic byte_order_swap, // high exchanges the bytes
  input wire logic output_format_select, // high offset binary, low two's complement
  input wire logic serial_chain_in, // daisy chain input, shift_clk domain
  input wire logic comparator_above, // analog comparator: sample above trial code
  output logic busy, // conversion in progress
  output logic [15:0] dac_code, // trial code for the capacitor array
  output logic nap_active, // reduced-power nap state
  output logic shutdown_active, // power shutdown state
  output logic [15:0] data_out, // parallel data
  output logic data_oe_n, // parallel output enable, low drives
  output logic serial_result_out, // serial data
  output logic serial_oe_n // serial output enable, low drives
);

  sar_adc_pkg::pin_bundle_t pins_raw;
  sar_adc_pkg::pin_bundle_t sync1_ff;
  sar_adc_pkg::pin_bundle_t pin_s;
  sar_adc_pkg::ctrl_state_t state_ff;
  logic conv_n_prev_ff;
  logic start_fall;
  logic busy_ff;
  logic [11:0] wait_ff;
  logic [7:0] step_ff;
  logic [3:0] idx_ff;
  logic [15:0] trial_ff;
  logic [15:0] result_ff;
  logic [15:0] bit_mask;
  logic [15:0] kept_trial;
  logic [15:0] data_out_ff;
  logic data_oe_n_ff;
  logic serial_oe_n_ff;
  logic [15:0] readout_word_ff;
  logic frame_clr;
  logic [4:0] rise_cnt_ff;
  logic [15:0] chain_sr_ff;
  logic [9:0] conv_len_ff;
  logic [15:0] fmt_word;
  logic chain_out_ff;

  function automatic logic [15:0] apply_format(input logic [15:0] raw, input logic fmt_ob);
    apply_format = {raw[15] ^ ~fmt_ob, raw[14:0]};
  endfunction

  assign pins_raw = '{conv_n: conversion_start_n, pd: power_down_request,
                      dev_reset: device_reset, cs_n: chip_select_n, rd_n: read_n,
                      ser_sel: interface_select, swap: byte_order_swap,
                      fmt_ob: output_format_select, cmp: comparator_above};

  // two-stage synchroniser for every pin read on clk
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_ff <= sar_adc_pkg::PINS_RST;
      pin_s <= sar_adc_pkg::PINS_RST;
    end else begin
      sync1_ff <= pins_raw;
      pin_s <= sync1_ff;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conv_n_prev_ff <= 1'b1;
    end else begin
      conv_n_prev_ff <= pin_s.conv_n;
    end
  end

  assign start_fall = conv_n_prev_ff & ~pin_s.conv_n;
  assign bit_mask = 16'h0001 << idx_ff;
  assign kept_trial = pin_s.cmp ? trial_ff : (trial_ff & ~bit_mask);

  // sequencing of recovery, acquisition, conversion, nap and shutdown
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= sar_adc_pkg::ST_RECOVER;
      busy_ff <= 1'b0;
      wait_ff <= sar_adc_pkg::WAIT_RST;
      step_ff <= sar_adc_pkg::STEP_RST;
      idx_ff <= sar_adc_pkg::TOP_BIT_IDX;
      trial_ff <= sar_adc_pkg::RESULT_RST;
      result_ff <= sar_adc_pkg::RESULT_RST;
    end else if (pin_s.dev_reset) begin
      state_ff <= sar_adc_pkg::ST_RECOVER;
      busy_ff <= 1'b0;
      wait_ff <= sar_adc_pkg::WAIT_RST;
    end else begin
      unique case (state_ff)
        sar_adc_pkg::ST_RECOVER: begin
          // starts are ignored until acquisition plus margin has passed
          if (wait_ff == 12'(sar_adc_pkg::RECOVER_CYC - 1)) begin
            state_ff <= sar_adc_pkg::ST_ACQUIRE;
            wait_ff <= sar_adc_pkg::WAIT_RST;
          end else begin
            wait_ff <= wait_ff + 12'h001;
          end
        end
        sar_adc_pkg::ST_ACQUIRE: begin
          if (pin_s.pd) begin
            state_ff <= sar_adc_pkg::ST_SHUTDOWN;
          end else if (start_fall) begin
            state_ff <= sar_adc_pkg::ST_CONVERT;
            busy_ff <= 1'b1;
            trial_ff <= sar_adc_pkg::TRIAL_START;
            idx_ff <= sar_adc_pkg::TOP_BIT_IDX;
            step_ff <= sar_adc_pkg::STEP_RST;
          end
        end
        sar_adc_pkg::ST_CONVERT: begin
          // start edges fall through here without effect
          if (step_ff == 8'(sar_adc_pkg::STEP_CYC - 1)) begin
            step_ff <= sar_adc_pkg::STEP_RST;
            trial_ff <= kept_trial | (bit_mask >> 1);
            idx_ff <= idx_ff - 4'h1;
            if (idx_ff == 4'h0) begin
              result_ff <= kept_trial;
              busy_ff <= 1'b0;
              if (pin_s.pd) begin
                state_ff <= sar_adc_pkg::ST_SHUTDOWN;
              end else if (!pin_s.conv_n) begin
                state_ff <= sar_adc_pkg::ST_NAP;
                wait_ff <= sar_adc_pkg::WAIT_RST;
              end else begin
                state_ff <= sar_adc_pkg::ST_ACQUIRE;
              end
            end
          end else begin
            step_ff <= step_ff + 8'h01;
          end
        end
        sar_adc_pkg::ST_NAP: begin
          if (pin_s.pd) begin
            state_ff <= sar_adc_pkg::ST_SHUTDOWN;
          end else if (!pin_s.conv_n) begin
            wait_ff <= sar_adc_pkg::WAIT_RST;
          end else if (wait_ff == 12'(sar_adc_pkg::NAP_WAKE_CYC - 1)) begin
            state_ff <= sar_adc_pkg::ST_ACQUIRE;
            wait_ff <= sar_adc_pkg::WAIT_RST;
          end else begin
            wait_ff <= wait_ff + 12'h001;
          end
        end
        sar_adc_pkg::ST_SHUTDOWN: begin
          if (!pin_s.pd) begin
            state_ff <= sar_adc_pkg::ST_ACQUIRE;
          end
        end
      endcase
    end
  end

  assign busy = busy_ff;
  assign dac_code = trial_ff;
  assign nap_active = (state_ff == sar_adc_pkg::ST_NAP);
  assign shutdown_active = (state_ff == sar_adc_pkg::ST_SHUTDOWN);

  // formatted result, shared by the parallel bus and the serial word copy
  assign fmt_word = apply_format(result_ff, pin_s.fmt_ob);

  // parallel bus and output enables
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_out_ff <= sar_adc_pkg::RESULT_RST;
      data_oe_n_ff <= 1'b1;
      serial_oe_n_ff <= 1'b1;
    end else begin
      if (pin_s.swap) begin
        data_out_ff <= {fmt_word[7:0], fmt_word[15:8]};
      end else begin
        data_out_ff <= fmt_word;
      end
      data_oe_n_ff <= pin_s.cs_n | pin_s.rd_n | pin_s.ser_sel | pin_s.dev_reset;
      serial_oe_n_ff <= pin_s.cs_n | pin_s.rd_n | ~pin_s.ser_sel | pin_s.dev_reset;
    end
  end

  assign data_out = data_out_ff;
  assign data_oe_n = data_oe_n_ff;
  assign serial_oe_n = serial_oe_n_ff;

  // word held still while a serial frame is open, so the shift side sees it settled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readout_word_ff <= sar_adc_pkg::RESULT_RST;
    end else if (serial_oe_n_ff) begin
      readout_word_ff <= fmt_word;
    end
  end

  // shift side: the frame gate itself clears the edge count, no edge after the frame
  assign frame_clr = rst | chip_select_n | read_n | ~interface_select | device_reset;

  always_ff @(posedge shift_clk or posedge frame_clr) begin
    if (frame_clr) begin
      rise_cnt_ff <= 5'h00;
    end else if (rise_cnt_ff != sar_adc_pkg::CHAIN_AT) begin
      rise_cnt_ff <= rise_cnt_ff + 5'h01;
    end
  end

  always_ff @(negedge shift_clk or posedge rst) begin
    if (rst) begin
      chain_sr_ff <= sar_adc_pkg::RESULT_RST;
    end else begin
      chain_sr_ff <= {chain_sr_ff[14:0], serial_chain_in};
    end
  end

  // chain bit retimed to the rising edge, so the pin never moves on a falling edge
  always_ff @(posedge shift_clk or posedge rst) begin
    if (rst) begin
      chain_out_ff <= 1'b0;
    end else begin
      chain_out_ff <= chain_sr_ff[15];
    end
  end

  // top bit before any rising edge, then one bit per rising edge, then the chain
  assign serial_result_out = (rise_cnt_ff == sar_adc_pkg::CHAIN_AT) ? chain_out_ff :
                             readout_word_ff[~rise_cnt_ff[3:0]];

  // length of the running conversion, only for checking
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conv_len_ff <= 10'h000;
    end else if (busy_ff) begin
      conv_len_ff <= conv_len_ff + 10'h001;
    end else begin
      conv_len_ff <= 10'h000;
    end
  end

  chk_start_sets_busy: assert property (@(posedge clk) disable iff (rst)
    (state_ff == sar_adc_pkg::ST_ACQUIRE) && start_fall && !pin_s.pd && !pin_s.dev_reset
    |=> busy_ff ##1 busy_ff)
    else $error("start edge did not raise busy");

  chk_restart_ignored: assert property (@(posedge clk) disable iff (rst)
    busy_ff && start_fall && !pin_s.dev_reset && conv_len_ff > 10'h001
    |=> conv_len_ff == $past(conv_len_ff) + 10'h001)
    else $error("conversion restarted by a start edge");

  chk_conv_time_max: assert property (@(posedge clk) disable iff (rst)
    busy_ff |-> conv_len_ff < 10'h1F4)
    else $error("conversion longer than allowed");

  chk_nap_entry: assert property (@(posedge clk) disable iff (rst)
    $fell(busy_ff) && !$past(pin_s.conv_n) && !$past(pin_s.pd) && !$past(pin_s.dev_reset)
    |-> nap_active)
    else $error("nap not entered with strobe held low");

  chk_shutdown_ignores: assert property (@(posedge clk) disable iff (rst)
    shutdown_active && pin_s.pd |=> !busy_ff ##1 !busy_ff)
    else $error("conversion started in shutdown");

  chk_pd_finishes: assert property (@(posedge clk) disable iff (rst)
    busy_ff && pin_s.pd && !pin_s.dev_reset |=> busy_ff || shutdown_active)
    else $error("power-down cut a conversion short");

  chk_gate_tristate: assert property (@(posedge clk) disable iff (rst)
    (pin_s.cs_n || pin_s.rd_n) |=> data_oe_n && serial_oe_n)
    else $error("outputs driven while not selected");

  chk_parallel_word: assert property (@(posedge clk) disable iff (rst)
    !data_oe_n && !busy_ff && $stable(result_ff) && $past(pin_s.swap) && !$past(pin_s.fmt_ob)
    |-> data_out == {result_ff[7:0], ~result_ff[15], result_ff[14:8]})
    else $error("swapped parallel word wrong");

  chk_reset_aborts: assert property (@(posedge clk) disable iff (rst)
    pin_s.dev_reset |=> !busy_ff && (state_ff == sar_adc_pkg::ST_RECOVER) && data_oe_n)
    else $error("reset pin did not abort");

  chk_parallel_select: assert property (@(posedge clk) disable iff (rst)
    !pin_s.cs_n && !pin_s.rd_n && !pin_s.ser_sel && !pin_s.dev_reset
    |=> !data_oe_n && serial_oe_n)
    else $error("parallel read not driven");

  chk_serial_select: assert property (@(posedge clk) disable iff (rst)
    !pin_s.cs_n && !pin_s.rd_n && pin_s.ser_sel && !pin_s.dev_reset
    |=> !serial_oe_n && data_oe_n)
    else $error("serial read not driven or bus not released");

  chk_plain_format: assert property (@(posedge clk) disable iff (rst)
    !data_oe_n && $stable(result_ff) && !$past(pin_s.swap) && $past(pin_s.fmt_ob)
    |-> data_out == result_ff)
    else $error("offset binary word wrong");

  chk_nap_holds: assert property (@(posedge clk) disable iff (rst)
    nap_active && !pin_s.conv_n && !pin_s.pd && !pin_s.dev_reset |=> nap_active)
    else $error("nap left while strobe held low");

  chk_recover_ignores: assert property (@(posedge clk) disable iff (rst)
    (state_ff == sar_adc_pkg::ST_RECOVER) && start_fall |=> !busy_ff)
    else $error("start accepted during recovery");

  chk_serial_top_bit: assert property (@(posedge shift_clk) disable iff (frame_clr)
    rise_cnt_ff == 5'h00 |-> serial_result_out == readout_word_ff[15])
    else $error("top bit not first on serial output");

  cov_conversion: cover property (@(posedge clk) disable iff (rst) $fell(busy_ff));
  cov_nap: cover property (@(posedge clk) disable iff (rst) $rose(nap_active));
  cov_swap_read: cover property (@(posedge clk) disable iff (rst) !data_oe_n && pin_s.swap);
  cov_shutdown: cover property (@(posedge clk) disable iff (rst)
    busy_ff && pin_s.pd ##[1:600] shutdown_active);
  cov_chain: cover property (@(posedge shift_clk) disable iff (frame_clr)
    rise_cnt_ff == sar_adc_pkg::CHAIN_AT);

endmodule

// File: bench/host_serial_reader.sv
// Purpose: host side of the serial readout, shifting one 32-bit frame per call
// Assumes: shift clock idles high and stands still outside frames; 160 ns period
// Notes: chain data comes from a notional upstream converter driven here
module host_serial_reader (
  output logic shift_clk, // host shift clock, idles high
  output logic serial_chain_in, // upstream converter data
  input wire logic serial_result_out, // serial data from the device
  input wire logic serial_oe_n // low while the device drives the pin
);
  timeunit 1ns;
  timeprecision 100ps;

  logic sdo_wire;

  // a released pin floats so a missing drive never matches
  assign sdo_wire = serial_oe_n ? 1'bz : serial_result_out;

  initial begin
    shift_clk = 1'b1;
    serial_chain_in = 1'b0;
  end

  task automatic frame(input logic [15:0] chain, output logic [31:0] got);
    // shift edges kept off the phase of the core clock
    #3.3;
    for (int i = 0; i < 32; i++) begin
      // upstream top bit goes in on the first falling edge
      if (i < 16) serial_chain_in = chain[15 - i];
      else serial_chain_in = ~serial_chain_in;
      #80;
      shift_clk = 1'b0;
      got[31 - i] = sdo_wire;
      #80;
      shift_clk = 1'b1;
    end
    serial_chain_in = ~serial_chain_in;
  endtask
endmodule

// File: bench/sar_adc_ctrl_bench.sv
// Purpose: self-checking bench for conversion sequencing, power states and readout
// Assumes: comparator modelled as sample >= trial code, so the result equals the sample
// Notes: pin changes land 1 ns after a rising clk edge, except shift clock and chain data at 4.3 ns
module sar_adc_ctrl_bench;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk, rst, shift_clk, conversion_start_n, power_down_request, device_reset;
  logic chip_select_n, read_n, interface_select, byte_order_swap, output_format_select;
  logic serial_chain_in, comparator_above, busy, nap_active, shutdown_active;
  logic data_oe_n, serial_result_out, serial_oe_n;
  logic [15:0] dac_code, data_out, sample;
  logic [31:0] got;
  int mismatches, n_checks, cycles;

  sar_adc_ctrl uut (.clk(clk), .rst(rst), .shift_clk(shift_clk),
    .conversion_start_n(conversion_start_n), .power_down_request(power_down_request),
    .device_reset(device_reset), .chip_select_n(chip_select_n), .read_n(read_n),
    .interface_select(interface_select), .byte_order_swap(byte_order_swap),
    .output_format_select(output_format_select), .serial_chain_in(serial_chain_in),
    .comparator_above(comparator_above), .busy(busy), .dac_code(dac_code),
    .nap_active(nap_active), .shutdown_active(shutdown_active), .data_out(data_out),
    .data_oe_n(data_oe_n), .serial_result_out(serial_result_out),
    .serial_oe_n(serial_oe_n));

  host_serial_reader host (.shift_clk(shift_clk), .serial_chain_in(serial_chain_in),
    .serial_result_out(serial_result_out), .serial_oe_n(serial_oe_n));

  assign comparator_above = (sample >= dac_code);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic final_report;
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      mismatches++;
      final_report;
    end
  end

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      mismatches++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic waitb(input logic v, input int lim, output int n);
    n = 0;
    while (busy !== v && n < lim) begin
      tick(1);
      n++;
    end
  endtask

  task automatic convert(input logic [15:0] s, input logic keep_low, input logic pd_mid);
    int n;
    realtime t0;
    sample = s;
    conversion_start_n = 1'b0;
    tick(4);
    conversion_start_n = !keep_low;
    check(busy, 1'b1);
    t0 = $realtime;
    tick(100);
    if (pd_mid) power_down_request = 1'b1;
    else if (!keep_low) begin
      // a second start edge in mid-conversion must not restart it
      conversion_start_n = 1'b0;
      tick(4);
      conversion_start_n = 1'b1;
    end
    waitb(1'b0, 600, n);
    n = int'(($realtime - t0) / 5.0);
    check(n >= 480 && n <= 500, 1'b1);
  endtask

  task automatic read_par(input logic swap, input logic ob, input logic by_rd);
    logic [15:0] w;
    w = ob ? sample : {~sample[15], sample[14:0]};
    interface_select = 1'b0;
    byte_order_swap = swap;
    output_format_select = ob;
    chip_select_n = 1'b0;
    read_n = 1'b0;
    tick(5);
    check(data_oe_n, 1'b0);
    check(data_out, swap ? {w[7:0], w[15:8]} : w);
    check(serial_oe_n, 1'b1);
    if (by_rd) read_n = 1'b1;
    else chip_select_n = 1'b1;
    tick(5);
    check(data_oe_n, 1'b1);
    chip_select_n = 1'b1;
    read_n = 1'b1;
    tick(1);
  endtask

  initial begin
    {rst, power_down_request, device_reset, byte_order_swap} = 4'hF;
    {power_down_request, device_reset, byte_order_swap, interface_select} = 4'h0;
    {conversion_start_n, chip_select_n, read_n, output_format_select} = 4'hF;
    {mismatches, n_checks, cycles} = '0;
    sample = 16'h0000;
    tick(2);
    rst = 1'b0;
    tick(720);
    convert(16'h1234, 1'b0, 1'b0);
    for (int i = 0; i < 8; i++) read_par(i[0], i[1], i[2]);
    interface_select = 1'b1;
    output_format_select = 1'b0;
    chip_select_n = 1'b0;
    read_n = 1'b0;
    tick(5);
    check(data_oe_n, 1'b1);
    host.frame(16'hA5C3, got);
    check(got[31:16], {~sample[15], sample[14:0]});
    check(got[15:0], 16'hA5C3);
    tick(1);
    chip_select_n = 1'b1;
    read_n = 1'b1;
    tick(5);
    check(serial_oe_n, 1'b1);
    convert(16'hFEDC, 1'b1, 1'b0);
    tick(5);
    check(nap_active, 1'b1);
    conversion_start_n = 1'b1;
    tick(10);
    conversion_start_n = 1'b0;
    tick(10);
    check(busy, 1'b0);
    conversion_start_n = 1'b1;
    tick(55);
    check(nap_active, 1'b0);
    read_par(1'b0, 1'b1, 1'b1);
    power_down_request = 1'b1;
    tick(5);
    check(shutdown_active, 1'b1);
    conversion_start_n = 1'b0;
    tick(4);
    conversion_start_n = 1'b1;
    tick(10);
    check(busy, 1'b0);
    power_down_request = 1'b0;
    tick(5);
    check(shutdown_active, 1'b0);
    convert(16'h8001, 1'b0, 1'b1);
    tick(5);
    check(shutdown_active, 1'b1);
    power_down_request = 1'b0;
    tick(5);
    read_par(1'b0, 1'b1, 1'b0);
    sample = 16'h7FFF;
    conversion_start_n = 1'b0;
    tick(4);
    conversion_start_n = 1'b1;
    chip_select_n = 1'b0;
    read_n = 1'b0;
    tick(50);
    device_reset = 1'b1;
    tick(5);
    check(busy, 1'b0);
    check(data_oe_n, 1'b1);
    conversion_start_n = 1'b0;
    tick(4);
    conversion_start_n = 1'b1;
    tick(10);
    check(busy, 1'b0);
    device_reset = 1'b0;
    chip_select_n = 1'b1;
    read_n = 1'b1;
    tick(720);
    convert(16'h4321, 1'b0, 1'b0);
    read_par(1'b1, 1'b0, 1'b0);
    final_report;
  end
endmodule
